// [radio_cfg_checker.sv]
// assertion checker for the radio packet configuration register block
`timescale 1ns/100ps
`include "radio_cfg_regs.vh"

module radio_cfg_checker (
    input logic        clk_in,
    input logic        rst_n_in,
    input logic        psel_in,
    input logic        penable_in,
    input logic        pwrite_in,
    input logic [11:0] paddr_in,
    input logic [31:0] pwdata_in,
    input logic [3:0]  pstrb_in,
    input logic [31:0] prdata_out,
    input logic        pready_out,
    input logic [10:0] radio_event_in,
    input logic        rx_done_in,
    input logic        check_passed_in,
    input logic [3:0]  rate_onehot_out,
    input logic [1:0]  modulation_out,
    input logic        irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // completed bus cycles; partial strobes are left out of the mask checks
    wire wr = psel_in & penable_in & pwrite_in & pready_out & (pstrb_in == 4'hF);
    wire rd = psel_in & penable_in & !pwrite_in & pready_out;
    // receive result, a quiet cycle, then a read setup of the status word
    sequence s_rx(ok);
        rx_done_in && check_passed_in == ok ##1 !rx_done_in
        ##1 !rx_done_in && psel_in && !penable_in && !pwrite_in && paddr_in == `OFS_RX_CHECK_STATUS;
    endsequence
    property p_zero_clear; wr && paddr_in == `OFS_IRQ_ENABLE_CLEAR && pwdata_in == 32'h0 && irq_out |=> irq_out; endproperty
    property p_mask_read; rd && paddr_in == `OFS_IRQ_ENABLE_CLEAR |-> (prdata_out & ~32'h4FF) == 32'h0 && (prdata_out != 32'h0 || !irq_out); endproperty
    property p_clear_all; wr && paddr_in == `OFS_IRQ_ENABLE_CLEAR && pwdata_in[10:0] == 11'h4FF |=> !irq_out; endproperty
    property p_set_one; wr && paddr_in == `OFS_IRQ_ENABLE_SET && pwdata_in[0] && radio_event_in[0] |=> irq_out; endproperty
    property p_check_ok; s_rx(1'h1) |=> prdata_out == 32'h1; endproperty
    property p_check_bad; s_rx(1'h0) |=> prdata_out == 32'h0; endproperty
    property p_rate; wr && paddr_in == `OFS_RATE_MODULATION |-> ##2 rate_onehot_out == 4'h1 << $past(pwdata_in[1:0], 2); endproperty
    property p_fsk; $changed(rate_onehot_out) |-> modulation_out == `MODULATION_FSK && $onehot(rate_onehot_out); endproperty
    property p_irq_rise; $rose(irq_out) |-> $past(|(radio_event_in & `EVT_VALID_MASK) || wr); endproperty
    property p_irq_fall; $fell(irq_out) |-> $past(wr && paddr_in != `OFS_IRQ_ENABLE_SET); endproperty
    a_zero_clear: assert property (p_zero_clear) else $error("zero clear dropped irq");
    a_mask_read: assert property (p_mask_read) else $error("clear register read wrong");
    a_clear_all: assert property (p_clear_all) else $error("irq stayed after clear");
    a_set_one: assert property (p_set_one) else $error("irq not raised by set");
    a_check_ok: assert property (p_check_ok) else $error("good packet status wrong");
    a_check_bad: assert property (p_check_bad) else $error("bad packet status wrong");
    a_rate: assert property (p_rate) else $error("rate one-hot wrong");
    a_fsk: assert property (p_fsk) else $error("modulation not fsk");
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without cause");
endmodule // radio_cfg_checker

bind radio_packet_config_regs radio_cfg_checker radio_cfg_checker_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .radio_event_in(radio_event_in),
    .rx_done_in(rx_done_in), .check_passed_in(check_passed_in), .rate_onehot_out(rate_onehot_out),
    .modulation_out(modulation_out), .irq_out(irq_out));

// [radio_cfg_regs.vh]
// register offsets, field positions and reset values of the radio packet configuration block
`ifndef RADIO_CFG_REGS_VH
`define RADIO_CFG_REGS_VH

// byte offsets on the apb bus
`define OFS_IRQ_ENABLE_SET        12'h304
`define OFS_IRQ_ENABLE_CLEAR      12'h308
`define OFS_EVENT_PENDING         12'h380
`define OFS_RX_CHECK_STATUS       12'h400
`define OFS_RX_MATCHED_ADDR       12'h408
`define OFS_RX_CHECK_FIELD        12'h40C
`define OFS_DEVICE_MATCH_INDEX    12'h410
`define OFS_PACKET_BUFFER_POINTER 12'h504
`define OFS_CHANNEL_FREQUENCY     12'h508
`define OFS_OUTPUT_POWER          12'h50C
`define OFS_RATE_MODULATION       12'h510
`define OFS_PACKET_FORMAT_0       12'h514
`define OFS_PACKET_FORMAT_1       12'h518

// event bit positions shared by enable, set, clear and pending registers
`define EVT_READY                 0
`define EVT_ADDRESS               1
`define EVT_PAYLOAD               2
`define EVT_END                   3
`define EVT_DISABLED              4
`define EVT_DEVICE_ADDRESS_HIT    5
`define EVT_DEVICE_ADDRESS_MISS   6
`define EVT_SIGNAL_STRENGTH_DONE  7
`define EVT_BIT_TALLY_HIT         10
`define EVT_COUNT                 11
`define EVT_VALID_MASK            11'h4FF

// rate selector codes
`define RATE_PROPRIETARY_ONE_MEG     2'h0
`define RATE_PROPRIETARY_TWO_MEG     2'h1
`define RATE_PROPRIETARY_QUARTER_MEG 2'h2
`define RATE_LOW_ENERGY_ONE_MEG      2'h3
`define RATE_MSB                     1
`define RATE_LSB                     0

// modulation codes, only frequency-shift keying exists
`define MODULATION_FSK            2'h0

// check status values
`define CHECK_FAILED              1'b0
`define CHECK_PASSED              1'b1

// field positions
`define FREQ_MSB                  6
`define POWER_MSB                 7
`define RX_MATCH_MSB              2
`define RX_CHECK_MSB              23
`define DEV_INDEX_MSB             2
`define FMT0_LENGTH_BITS_MSB      3
`define FMT0_LENGTH_BITS_LSB      0
`define FMT0_S0_BYTES_BIT         8
`define FMT0_S1_BITS_MSB          19
`define FMT0_S1_BITS_LSB          16
`define FMT1_MAX_LEN_MSB          7
`define FMT1_MAX_LEN_LSB          0
`define FMT1_STATIC_LEN_MSB       15
`define FMT1_STATIC_LEN_LSB       8
`define FMT1_BASE_LEN_MSB         18
`define FMT1_BASE_LEN_LSB         16
`define FMT1_BIG_ENDIAN_BIT       24

// reset values
`define RST_WORD                  32'h0000_0000
`define RST_EVENTS                11'h000

`endif

// [radio_event_flags.v]
// sticky event flags with write-one-to-clear and set-over-clear priority
`timescale 1ns/100ps

module radio_event_flags #(
    parameter WIDTH = 11
) (
    input  wire             clk_in,
    input  wire             rst_n_in,
    input  wire [WIDTH-1:0] event_in,
    input  wire [WIDTH-1:0] clear_in,
    input  wire [WIDTH-1:0] valid_in,
    output wire [WIDTH-1:0] pending_out
);

    reg [WIDTH-1:0] pending;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
            // a new event on a valid bit in the clear cycle survives so no valid event is lost
            always @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    pending[i] <= 1'b0;
                end else if (valid_in[i] && event_in[i]) begin
                    pending[i] <= 1'b1;
                end else if (clear_in[i]) begin
                    pending[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign pending_out = pending;

endmodule // radio_event_flags

// [radio_packet_config_regs.v]
// apb register block of the packet radio: interrupt enables, receive status and packet configuration
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "radio_cfg_regs.vh"

// Functional notes
// (R1) writing zero to an enable-clear bit leaves that interrupt enable alone
// (R2) reading the enable-clear register returns the live combined enable mask
// (R3) writing one to an enable-clear bit disables that event's interrupt
// (R4) writing one to an enable-set bit enables that event's interrupt
// (R5) check status reads one after a good packet, zero after a checksum error
// (R6) rate selector codes 0..3 pick 1M, 2M, 250k proprietary or 1M low energy
// (R7) every rate uses frequency-shift keying
// (R8) interrupt output is high while any enabled event flag is set
module radio_packet_config_regs (
    input  wire                   clk_in,
    input  wire                   rst_n_in,
    // apb slave
    input  wire                   psel_in,
    input  wire                   penable_in,
    input  wire                   pwrite_in,
    input  wire [11:0]            paddr_in,
    input  wire [31:0]            pwdata_in,
    input  wire [3:0]             pstrb_in,
    output reg  [31:0]            prdata_out,
    output wire                   pready_out,
    output wire                   pslverr_out,
    // event pulses from the packet state machine, bit positions as in the enable registers
    input  wire [`EVT_COUNT-1:0]  radio_event_in,
    // receive results, captured on rx_done_in
    input  wire                   rx_done_in,
    input  wire                   check_passed_in,
    input  wire [`RX_MATCH_MSB:0] rx_match_in,
    input  wire [`RX_CHECK_MSB:0] rx_check_in,
    input  wire                   device_hit_in,
    input  wire [`DEV_INDEX_MSB:0] device_index_in,
    // configuration towards the packet state machine
    output reg  [31:0]            packet_ptr_out,
    output reg  [`FREQ_MSB:0]     frequency_out,
    output reg  [`POWER_MSB:0]    tx_power_out,
    output reg  [3:0]             rate_onehot_out,
    output reg  [1:0]             modulation_out,
    output reg  [3:0]             length_field_bits_out,
    output reg                    s0_field_bytes_out,
    output reg  [3:0]             s1_field_bits_out,
    output reg  [7:0]             max_payload_out,
    output reg  [7:0]             static_length_out,
    output reg  [2:0]             base_addr_bytes_out,
    output reg                    big_endian_out,
    output wire                   irq_out
);

    // register storage
    reg  [`EVT_COUNT-1:0]    irq_enable_mask;
    reg                      check_status;
    reg  [`RX_MATCH_MSB:0]   rx_matched_logical_address;
    reg  [`RX_CHECK_MSB:0]   rx_check_field;
    reg  [`DEV_INDEX_MSB:0]  device_match_index;
    reg  [31:0]              packet_buffer_pointer;
    reg  [`FREQ_MSB:0]       channel_frequency;
    reg  [`POWER_MSB:0]      output_power;
    reg  [`RATE_MSB:0]       rate_modulation_select;
    reg  [31:0]              packet_format_0;
    reg  [31:0]              packet_format_1;

    // bus decode
    wire                     setup_phase;
    wire                     access_phase;
    wire                     write_access;
    wire [31:0]              byte_mask;
    wire [31:0]              wdata_masked;
    wire [`EVT_COUNT-1:0]    wdata_events;
    reg                      addr_hit;
    reg  [31:0]              next_rdata;
    wire [`EVT_COUNT-1:0]    event_pending;
    wire [`EVT_COUNT-1:0]    pending_clear;

    assign setup_phase  = psel_in & ~penable_in;
    assign access_phase = psel_in & penable_in;
    assign write_access = access_phase & pwrite_in;

    // byte enables turn into a bit mask so partial writes touch only their lanes
    assign byte_mask    = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
    assign wdata_masked = pwdata_in & byte_mask;
    assign wdata_events = wdata_masked[`EVT_COUNT-1:0] & `EVT_VALID_MASK;

    // read data is latched in the setup cycle, so every access completes with no wait state
    assign pready_out  = 1'b1;
    assign pslverr_out = access_phase & ~addr_hit;

    // address decode and read multiplexer
    always @* begin
        addr_hit   = 1'b1;
        next_rdata = `RST_WORD;
        case (paddr_in)
            `OFS_IRQ_ENABLE_SET:        next_rdata[`EVT_COUNT-1:0] = irq_enable_mask;
            `OFS_IRQ_ENABLE_CLEAR:      next_rdata[`EVT_COUNT-1:0] = irq_enable_mask; // R2
            `OFS_EVENT_PENDING:         next_rdata[`EVT_COUNT-1:0] = event_pending;
            `OFS_RX_CHECK_STATUS:       next_rdata[0] = check_status; // R5
            `OFS_RX_MATCHED_ADDR:       next_rdata[`RX_MATCH_MSB:0] = rx_matched_logical_address;
            `OFS_RX_CHECK_FIELD:        next_rdata[`RX_CHECK_MSB:0] = rx_check_field;
            `OFS_DEVICE_MATCH_INDEX:    next_rdata[`DEV_INDEX_MSB:0] = device_match_index;
            `OFS_PACKET_BUFFER_POINTER: next_rdata = packet_buffer_pointer;
            `OFS_CHANNEL_FREQUENCY:     next_rdata[`FREQ_MSB:0] = channel_frequency;
            `OFS_OUTPUT_POWER:          next_rdata[`POWER_MSB:0] = output_power;
            `OFS_RATE_MODULATION:       next_rdata[`RATE_MSB:0] = rate_modulation_select;
            `OFS_PACKET_FORMAT_0:       next_rdata = packet_format_0;
            `OFS_PACKET_FORMAT_1:       next_rdata = packet_format_1;
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // read data register, refreshed only in setup cycles of reads so it holds through the access
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_out <= `RST_WORD;
        end else if (setup_phase && !pwrite_in) begin
            prdata_out <= next_rdata;
        end
    end

    // interrupt enable mask: set and clear registers act on the one stored mask
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_enable_mask <= `RST_EVENTS;
        end else if (write_access && paddr_in == `OFS_IRQ_ENABLE_SET) begin
            irq_enable_mask <= irq_enable_mask | wdata_events; // R4
        end else if (write_access && paddr_in == `OFS_IRQ_ENABLE_CLEAR) begin
            irq_enable_mask <= irq_enable_mask & ~wdata_events; // R1 R3
        end
    end

    // writable configuration registers
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            packet_buffer_pointer  <= `RST_WORD;
            channel_frequency      <= {(`FREQ_MSB+1){1'b0}};
            output_power           <= {(`POWER_MSB+1){1'b0}};
            rate_modulation_select <= `RATE_PROPRIETARY_ONE_MEG;
            packet_format_0        <= `RST_WORD;
            packet_format_1        <= `RST_WORD;
        end else if (write_access) begin
            case (paddr_in)
                `OFS_PACKET_BUFFER_POINTER: begin
                    packet_buffer_pointer <= (packet_buffer_pointer & ~byte_mask) | wdata_masked;
                end
                `OFS_CHANNEL_FREQUENCY: begin
                    if (pstrb_in[0]) begin
                        channel_frequency <= pwdata_in[`FREQ_MSB:0];
                    end
                end
                `OFS_OUTPUT_POWER: begin
                    if (pstrb_in[0]) begin
                        output_power <= pwdata_in[`POWER_MSB:0];
                    end
                end
                `OFS_RATE_MODULATION: begin
                    if (pstrb_in[0]) begin
                        rate_modulation_select <= pwdata_in[`RATE_MSB:0];
                    end
                end
                `OFS_PACKET_FORMAT_0: begin
                    packet_format_0 <= (packet_format_0 & ~byte_mask) | wdata_masked;
                end
                `OFS_PACKET_FORMAT_1: begin
                    packet_format_1 <= (packet_format_1 & ~byte_mask) | wdata_masked;
                end
                default: begin
                    packet_buffer_pointer <= packet_buffer_pointer;
                end
            endcase
        end
    end

    // receive results are captured once per packet; status only changes when a packet ends
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            check_status               <= `CHECK_FAILED;
            rx_matched_logical_address <= {(`RX_MATCH_MSB+1){1'b0}};
            rx_check_field             <= {(`RX_CHECK_MSB+1){1'b0}};
            device_match_index         <= {(`DEV_INDEX_MSB+1){1'b0}};
        end else if (rx_done_in) begin
            check_status               <= check_passed_in ? `CHECK_PASSED : `CHECK_FAILED; // R5
            rx_matched_logical_address <= rx_match_in;
            rx_check_field             <= rx_check_in;
            if (device_hit_in) begin
                device_match_index <= device_index_in;
            end
        end
    end

    // pending flags clear by writing ones to the pending register
    assign pending_clear = (write_access && paddr_in == `OFS_EVENT_PENDING) ? wdata_events : `RST_EVENTS;

    radio_event_flags #(
        .WIDTH       (`EVT_COUNT)
    ) u_event_flags (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .event_in    (radio_event_in),
        .clear_in    (pending_clear),
        .valid_in    (`EVT_VALID_MASK),
        .pending_out (event_pending)
    );

    // level interrupt; masking after the flag lets software poll disabled events
    assign irq_out = |(event_pending & irq_enable_mask); // R8

    // configuration outputs registered so the state machine sees glitch-free fields
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            packet_ptr_out        <= `RST_WORD;
            frequency_out         <= {(`FREQ_MSB+1){1'b0}};
            tx_power_out          <= {(`POWER_MSB+1){1'b0}};
            rate_onehot_out       <= 4'h1;
            modulation_out        <= `MODULATION_FSK;
            length_field_bits_out <= 4'h0;
            s0_field_bytes_out    <= 1'b0;
            s1_field_bits_out     <= 4'h0;
            max_payload_out       <= 8'h00;
            static_length_out     <= 8'h00;
            base_addr_bytes_out   <= 3'h0;
            big_endian_out        <= 1'b0;
        end else begin
            packet_ptr_out        <= packet_buffer_pointer;
            frequency_out         <= channel_frequency;
            tx_power_out          <= output_power;
            modulation_out        <= `MODULATION_FSK; // R7
            length_field_bits_out <= packet_format_0[`FMT0_LENGTH_BITS_MSB:`FMT0_LENGTH_BITS_LSB];
            s0_field_bytes_out    <= packet_format_0[`FMT0_S0_BYTES_BIT];
            s1_field_bits_out     <= packet_format_0[`FMT0_S1_BITS_MSB:`FMT0_S1_BITS_LSB];
            max_payload_out       <= packet_format_1[`FMT1_MAX_LEN_MSB:`FMT1_MAX_LEN_LSB];
            static_length_out     <= packet_format_1[`FMT1_STATIC_LEN_MSB:`FMT1_STATIC_LEN_LSB];
            base_addr_bytes_out   <= packet_format_1[`FMT1_BASE_LEN_MSB:`FMT1_BASE_LEN_LSB];
            big_endian_out        <= packet_format_1[`FMT1_BIG_ENDIAN_BIT];
            // one-hot rate: bit0 1M prop, bit1 2M prop, bit2 250k prop, bit3 1M low energy
            case (rate_modulation_select)
                `RATE_PROPRIETARY_ONE_MEG:     rate_onehot_out <= 4'h1; // R6
                `RATE_PROPRIETARY_TWO_MEG:     rate_onehot_out <= 4'h2; // R6
                `RATE_PROPRIETARY_QUARTER_MEG: rate_onehot_out <= 4'h4; // R6
                `RATE_LOW_ENERGY_ONE_MEG:      rate_onehot_out <= 4'h8; // R6
                default:                       rate_onehot_out <= 4'h1;
            endcase
        end
    end

endmodule // radio_packet_config_regs

// [tb_top.sv]
// self-checking testbench for the radio packet configuration register block
`timescale 1ns/100ps
`include "radio_cfg_regs.vh"

module tb_top;
    logic        clk_in;
    logic        rst_n_in;
    logic        psel_in;
    logic        penable_in;
    logic        pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in;
    logic [10:0] radio_event_in;
    logic        rx_done_in;
    logic        check_passed_in;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic [3:0]  rate_onehot_out;
    logic [1:0]  modulation_out;
    logic        irq_out;
    logic [31:0] rdat;
    logic        rerr;
    int          error_cnt = 0;
    int          comparisons = 0;

    // receive side fields beyond the check bit are tied off to save length
    radio_packet_config_regs radio_packet_config_regs_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(4'hF),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .radio_event_in(radio_event_in), .rx_done_in(rx_done_in), .check_passed_in(check_passed_in),
        .rx_match_in(3'h0), .rx_check_in(24'h0), .device_hit_in(1'h0), .device_index_in(3'h0),
        .packet_ptr_out(), .frequency_out(), .tx_power_out(), .rate_onehot_out(rate_onehot_out),
        .modulation_out(modulation_out), .length_field_bits_out(), .s0_field_bytes_out(),
        .s1_field_bits_out(), .max_payload_out(), .static_length_out(), .base_addr_bytes_out(),
        .big_endian_out(), .irq_out(irq_out));

    initial begin
        clk_in = 1'h0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic results();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one transfer; request held until pready is seen high, bounded wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'h1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'h1;
        @(posedge clk_in);
        while (pready_out !== 1'h1 && n < 16) begin
            @(posedge clk_in);
            n++;
        end
        if (n == 16) begin
            error_cnt++;
            $display("BAD pready expected 1 seen 0");
            results();
        end
        rdat = prdata_out;
        rerr = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(what, exp, rdat);
    endtask

    task automatic irq_chk(input logic exp);
        @(negedge clk_in);
        chk("irq", exp, irq_out);
    endtask

    // defaults after reset, plus an unmapped address
    task automatic reset_state();
        chk("rate", 32'h1, rate_onehot_out);
        rd_chk("enable clear", `OFS_IRQ_ENABLE_CLEAR, 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        chk("unmapped error", 32'h1, rerr);
        chk("unmapped data", 32'h0, rdat);
    endtask

    // set all enables, then drop them one at a time; a zero write must change nothing
    task automatic enables();
        logic [31:0] exp;
        exp = 32'h4FF;
        apb(1'h1, `OFS_IRQ_ENABLE_SET, 32'hFFFF_FFFF);
        apb(1'h1, `OFS_IRQ_ENABLE_CLEAR, 32'h0);
        rd_chk("mask", `OFS_IRQ_ENABLE_CLEAR, exp);
        for (int b = 0; b < `EVT_COUNT; b++) begin
            if (exp[b]) begin
                apb(1'h1, `OFS_IRQ_ENABLE_CLEAR, 32'h1 << b);
                exp[b] = 1'h0;
                rd_chk("mask", `OFS_IRQ_ENABLE_CLEAR, exp);
            end
        end
    endtask

    // masked event stays silent; enabling raises the line; mask or flag clear drops it
    task automatic interrupts();
        @(posedge clk_in);
        radio_event_in <= 11'h008;
        @(posedge clk_in);
        radio_event_in <= 11'h001;
        irq_chk(1'h0);
        apb(1'h1, `OFS_IRQ_ENABLE_SET, 32'h1);
        radio_event_in <= 11'h000;
        irq_chk(1'h1);
        apb(1'h1, `OFS_IRQ_ENABLE_CLEAR, 32'h0);
        irq_chk(1'h1);
        apb(1'h1, `OFS_IRQ_ENABLE_CLEAR, 32'h4FF);
        irq_chk(1'h0);
        apb(1'h1, `OFS_IRQ_ENABLE_SET, 32'h8);
        irq_chk(1'h1);
        apb(1'h1, `OFS_EVENT_PENDING, 32'hFFFF_FFFF);
        irq_chk(1'h0);
    endtask

    // each receive result shows in the status word read right after it
    task automatic rx_status();
        for (int ok = 1; ok >= 0; ok--) begin
            @(posedge clk_in);
            rx_done_in <= 1'h1;
            check_passed_in <= ok[0];
            @(posedge clk_in);
            rx_done_in <= 1'h0;
            rd_chk("check status", `OFS_RX_CHECK_STATUS, ok);
        end
    endtask

    // every rate code drives its own one-hot line and keeps fsk
    task automatic rates();
        for (int v = 3; v >= 0; v--) begin
            apb(1'h1, `OFS_RATE_MODULATION, v);
            @(posedge clk_in);
            @(negedge clk_in);
            chk("rate", 32'h1 << v, rate_onehot_out);
            chk("modulation", `MODULATION_FSK, modulation_out);
            rd_chk("rate readback", `OFS_RATE_MODULATION, v);
        end
    endtask

    initial begin
        rst_n_in = 1'h0;
        psel_in = 1'h0;
        penable_in = 1'h0;
        pwrite_in = 1'h0;
        paddr_in = 12'h0;
        pwdata_in = 32'h0;
        radio_event_in = 11'h0;
        rx_done_in = 1'h0;
        check_passed_in = 1'h0;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'h1;
        reset_state();
        enables();
        interrupts();
        rx_status();
        rates();
        results();
    end
endmodule // tb_top
